// ---- szt_pkg.sv ----
package szt_pkg;

  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int TARE_WAIT_S = 3;
  localparam int TARE_WAIT_CYC = TARE_WAIT_S * CLK_HZ;

  // Arithmetic and codes
  localparam int PCT_FULL = 100;
  localparam logic [7:0] ASCII_Z = 8'h5a;
  localparam logic [7:0] ASCII_LO_A = 8'h61;
  localparam logic [7:0] ASCII_LO_Z = 8'h7a;
  localparam logic [7:0] ASCII_CASE = 8'h20;

  // Values after reset, and the count width
  localparam logic PU_EN_RST = 1'b0;
  localparam int SYNC_RST = 0;
  localparam int COUNT_W = 16;

  // Tare label shown beside the tare field
  typedef enum logic [1:0] {SZT_LBL_NONE, SZT_LBL_T, SZT_LBL_PRESET, SZT_LBL_M} szt_label_t;

  // Power-up zero sequence
  typedef enum logic {SZT_PU_WAIT, SZT_PU_DONE} szt_pu_t;

  // Pushbutton tare sequence
  typedef enum logic {SZT_TR_IDLE, SZT_TR_WAIT} szt_tare_st_t;

endpackage

// ---- szt_tare_table.sv ----
`timescale 1ns/1ps
module szt_tare_table
  import szt_pkg::*;
#(
  parameter int W = 24,
  parameter int TW = 32,
  parameter int N_REC = 16,
  parameter int ID_CHARS = 4,
  parameter int DESC_CHARS = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Record definition
  input wire logic wr_en,
  input wire logic [$clog2(N_REC)-1:0] wr_idx,
  input wire logic [8*ID_CHARS-1:0] wr_id,
  input wire logic [8*DESC_CHARS-1:0] wr_desc,
  input wire logic [W-1:0] wr_tare,
  // Preset store and totalization
  input wire logic pre_wr_en,
  input wire logic tot_en,
  input wire logic [$clog2(N_REC)-1:0] act_idx,
  input wire logic [W-1:0] pre_wr_val,
  input wire logic [W-1:0] tot_val,
  // Identifier lookup and reads
  input wire logic [8*ID_CHARS-1:0] look_id,
  output logic look_hit,
  output logic [$clog2(N_REC)-1:0] look_idx,
  input wire logic [$clog2(N_REC)-1:0] rec_idx,
  output logic [W-1:0] rec_tare,
  output logic [8*DESC_CHARS-1:0] sel_desc,
  output logic [TW-1:0] sel_total,
  output logic [COUNT_W-1:0] sel_count
);

  localparam int IW = $clog2(N_REC);

  logic [N_REC-1:0] valid_q;
  logic [8*ID_CHARS-1:0] id_mem [N_REC];
  logic [8*DESC_CHARS-1:0] desc_mem [N_REC];
  logic [W-1:0] tare_mem [N_REC];
  logic [TW-1:0] total_mem [N_REC];
  logic [COUNT_W-1:0] count_mem [N_REC];

  // Fold lower case onto upper case
  function automatic logic [7:0] upc(input logic [7:0] c);
    if (c >= ASCII_LO_A && c <= ASCII_LO_Z) begin
      return c - ASCII_CASE;
    end
    return c;
  endfunction

  // Valid bits only; data arrays stay unreset to keep them as plain RAM
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_q <= '0;
    end else if (wr_en) begin
      valid_q[wr_idx] <= 1'b1;
    end
  end

  // Definition, preset store and running totals
  always_ff @(posedge clk) begin
    if (wr_en) begin
      id_mem[wr_idx] <= wr_id;
      desc_mem[wr_idx] <= wr_desc;
      tare_mem[wr_idx] <= wr_tare;
      total_mem[wr_idx] <= '0;
      count_mem[wr_idx] <= '0;
    end else begin
      if (pre_wr_en) begin
        tare_mem[act_idx] <= pre_wr_val;
      end
      if (tot_en) begin
        total_mem[act_idx] <= total_mem[act_idx] + {{(TW-W){tot_val[W-1]}}, tot_val};
        count_mem[act_idx] <= count_mem[act_idx] + COUNT_W'(1);
      end
    end
  end

  // Case-blind identifier search, lowest index wins
  always_comb begin
    logic m;
    look_hit = 1'b0;
    look_idx = '0;
    m = 1'b0;
    for (int i = N_REC - 1; i >= 0; i--) begin
      m = valid_q[i];
      for (int c = 0; c < ID_CHARS; c++) begin
        m = m && (upc(id_mem[i][8*c +: 8]) == upc(look_id[8*c +: 8]));
      end
      if (m) begin
        look_hit = 1'b1;
        look_idx = IW'(i);
      end
    end
  end

  assign rec_tare = tare_mem[rec_idx];

  // Selected record view, one cycle behind the index
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_desc <= '0;
      sel_total <= '0;
      sel_count <= '0;
    end else begin
      sel_desc <= desc_mem[act_idx];
      sel_total <= total_mem[act_idx];
      sel_count <= count_mem[act_idx];
    end
  end

endmodule // szt_tare_table

// ---- szt_zero_tare.sv ----
`timescale 1ns/1ps
module szt_zero_tare
  import szt_pkg::*;
#(
  parameter int W = 24,
  parameter int PCT_W = 7,
  parameter int N_REC = 16,
  parameter int ID_CHARS = 4,
  parameter int DESC_CHARS = 40,
  parameter int TARE_WAIT = TARE_WAIT_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Front end, same clock
  input wire logic [W-1:0] RAW_WT,
  input wire logic MOTION,
  input wire logic OVER_CAP,
  input wire logic UNDER_ZERO,
  input wire logic [W-1:0] CAPACITY,
  input wire logic [W-1:0] DISP_INT,
  // Configuration
  input wire logic PWRUP_ZERO_EN,
  input wire logic [PCT_W-1:0] PWRUP_PCT_ABOVE,
  input wire logic [PCT_W-1:0] PWRUP_PCT_BELOW,
  input wire logic [PCT_W-1:0] SEMI_ZERO_PCT,
  input wire logic PB_TARE_EN,
  input wire logic KB_TARE_EN,
  input wire logic NET_SIGN_CORR_EN,
  input wire logic TOTAL_EN,
  input wire logic TOTAL_SEL_NET,
  // Pins, asynchronous
  input wire logic ZERO_KEY,
  input wire logic TARE_KEY,
  input wire logic ZERO_DIN,
  // Zero requests, same clock
  input wire logic SER_RX_VALID,
  input wire logic [7:0] SER_RX_CHAR,
  input wire logic PLC_ZERO,
  input wire logic APP_ZERO,
  // Preset tare sources
  input wire logic KEY_ENTRY_VALID,
  input wire logic [W-1:0] KEY_ENTRY_VAL,
  input wire logic SER_PRE_VALID,
  input wire logic [W-1:0] SER_PRE_VAL,
  input wire logic PLC_PRE_VALID,
  input wire logic [W-1:0] PLC_PRE_VAL,
  // Tare table
  input wire logic TBL_WR_EN,
  input wire logic [$clog2(N_REC)-1:0] TBL_WR_IDX,
  input wire logic [8*ID_CHARS-1:0] TBL_WR_ID,
  input wire logic [8*DESC_CHARS-1:0] TBL_WR_DESC,
  input wire logic [W-1:0] TBL_WR_TARE,
  input wire logic TBL_RECALL_IDX_VALID,
  input wire logic [$clog2(N_REC)-1:0] TBL_RECALL_IDX,
  input wire logic TBL_RECALL_ID_VALID,
  input wire logic [8*ID_CHARS-1:0] TBL_RECALL_ID,
  input wire logic TXN_DONE,
  // Weight results
  output logic [W-1:0] DISP_GROSS,
  output logic [W-1:0] DISP_TARE,
  output logic [W-1:0] DISP_NET,
  output logic [W-1:0] ZERO_REF,
  output logic NET_MODE,
  output logic [1:0] TARE_LABEL,
  output logic PU_ZERO_DONE,
  output logic TARE_WAITING,
  // Record view
  output logic [$clog2(N_REC)-1:0] TBL_SEL_IDX,
  output logic [8*DESC_CHARS-1:0] TBL_DESC,
  output logic [W+7:0] TBL_TOTAL,
  output logic [COUNT_W-1:0] TBL_COUNT,
  // Error pulses
  output logic ERR_ZERO_RANGE,
  output logic ERR_TARE_MOTION,
  output logic ERR_TARE_SMALL,
  output logic ERR_TARE_OVERCAP,
  output logic ERR_TARE_BELOW_ZERO,
  output logic ERR_TARE_RANGE,
  output logic ERR_TBL_MISS
);

  localparam int IW = $clog2(N_REC);
  localparam int CW = $clog2(TARE_WAIT + 1);
  localparam int NPIN = 3;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  // Percentage of capacity, widened by one sign bit
  function automatic logic signed [W:0] pct_of(input logic [PCT_W-1:0] p, input logic [W-1:0] cap);
    logic [W+PCT_W-1:0] prod;
    prod = (W+PCT_W)'(p) * (W+PCT_W)'(cap);
    return $signed((W+1)'(prod / (W+PCT_W)'(PCT_FULL)));
  endfunction

  // Half-up rounding to the display interval
  function automatic logic [W-1:0] round_int(input logic [W-1:0] v, input logic [W-1:0] d);
    logic [W-1:0] q;
    logic [W-1:0] r;
    if (d == '0) begin
      return v;
    end
    q = v / d;
    r = v - W'(q * d);
    if ({r, 1'b0} >= {1'b0, d}) begin
      q = q + W'(1);
    end
    return W'(q * d);
  endfunction

  // Three-stage pin synchronisers; a level counts once stages two and three agree
  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, stab_q, pin_rise;
  assign pin_in = {ZERO_DIN, TARE_KEY, ZERO_KEY};
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        s1_q[g] <= 1'(SYNC_RST);
        s2_q[g] <= 1'(SYNC_RST);
        s3_q[g] <= 1'(SYNC_RST);
        stab_q[g] <= 1'(SYNC_RST);
      end else begin
        s1_q[g] <= pin_in[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          stab_q[g] <= s3_q[g];
        end
      end
    end
    assign pin_rise[g] = (s2_q[g] == s3_q[g]) && s3_q[g] && !stab_q[g];
  end

  // Weight arithmetic, all one bit wider to keep sign
  logic signed [W:0] raw_x, zref_x, init_x, gross_x, semi_dev, pu_band_hi, pu_band_lo, semi_band;
  logic [W-1:0] zero_ref_q, init_zero_q;
  logic in_pu_band, in_semi_band, zero_req;
  assign raw_x = $signed({RAW_WT[W-1], RAW_WT});
  assign zref_x = $signed({zero_ref_q[W-1], zero_ref_q});
  assign init_x = $signed({init_zero_q[W-1], init_zero_q});
  assign gross_x = raw_x - zref_x;
  assign pu_band_hi = pct_of(PWRUP_PCT_ABOVE, CAPACITY);
  assign pu_band_lo = -pct_of(PWRUP_PCT_BELOW, CAPACITY);
  assign in_pu_band = (raw_x <= pu_band_hi) && (raw_x >= pu_band_lo);
  assign semi_dev = raw_x - (PWRUP_ZERO_EN ? init_x : '0);
  assign semi_band = pct_of(SEMI_ZERO_PCT, CAPACITY);
  assign in_semi_band = (semi_dev <= semi_band) && (semi_dev >= -semi_band);
  assign zero_req = pin_rise[0] || pin_rise[2] || (SER_RX_VALID && SER_RX_CHAR == ASCII_Z) || PLC_ZERO || APP_ZERO;

  // Power-up zero: waits as long as motion lasts, no timeout by design
  szt_pu_t pu_st_q;
  logic pu_take, semi_take;
  assign pu_take = (pu_st_q == SZT_PU_WAIT) && PWRUP_ZERO_EN && !MOTION && in_pu_band;
  assign semi_take = (pu_st_q == SZT_PU_DONE) && zero_req && !MOTION && in_semi_band;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pu_st_q <= SZT_PU_WAIT;
    end else begin
      case (pu_st_q)
        SZT_PU_WAIT: begin
          if (!PWRUP_ZERO_EN || !MOTION) begin
            pu_st_q <= SZT_PU_DONE;
          end
        end
        SZT_PU_DONE: pu_st_q <= SZT_PU_DONE;
        default: pu_st_q <= SZT_PU_WAIT;
      endcase
    end
  end

  // Zero reference and the initial zero that centres the semi band
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      zero_ref_q <= '0;
      init_zero_q <= '0;
    end else if (pu_take) begin
      zero_ref_q <= RAW_WT;
      init_zero_q <= RAW_WT;
    end else if (semi_take) begin
      zero_ref_q <= RAW_WT;
    end
  end

  a_pu_motion_hold: assert property ((pu_st_q == SZT_PU_WAIT) && MOTION |=> $stable(zero_ref_q))
    else $error("power-up zero moved during motion");
  a_semi_band_reject: assert property ((pu_st_q == SZT_PU_DONE) && zero_req && !MOTION && !in_semi_band
    |=> $stable(zero_ref_q) && ERR_ZERO_RANGE)
    else $error("out-of-band zero was accepted");

  // Tare requests from the key and the preset sources
  logic [W-1:0] gross_w, tare_q, pre_val, pre_round;
  logic kb_req, pb_req, tbl_req, tbl_miss, pre_req, pre_ok, pre_oc, pre_uz, pre_big;
  logic pb_small, pb_exec, wait_to;
  logic [IW-1:0] tbl_idx, look_idx, sel_q;
  logic look_hit, rec_act_q, net_mode_q;
  logic [W-1:0] rec_tare;
  szt_tare_st_t st_q;
  szt_label_t label_q;
  logic [CW-1:0] wcnt_q;
  assign gross_w = gross_x[W-1:0];
  assign kb_req = pin_rise[1] && KEY_ENTRY_VALID && KB_TARE_EN;
  assign pb_req = pin_rise[1] && !KEY_ENTRY_VALID && PB_TARE_EN;
  assign tbl_idx = TBL_RECALL_IDX_VALID ? TBL_RECALL_IDX : look_idx;
  assign tbl_req = TBL_RECALL_IDX_VALID || (TBL_RECALL_ID_VALID && look_hit);
  assign tbl_miss = !TBL_RECALL_IDX_VALID && TBL_RECALL_ID_VALID && !look_hit;
  assign pre_req = kb_req || SER_PRE_VALID || PLC_PRE_VALID || tbl_req;

  // Preset value, keypad first, then serial, PLC, table
  always_comb begin
    if (kb_req) begin
      pre_val = KEY_ENTRY_VAL;
    end else if (SER_PRE_VALID) begin
      pre_val = SER_PRE_VAL;
    end else if (PLC_PRE_VALID) begin
      pre_val = PLC_PRE_VAL;
    end else begin
      pre_val = rec_tare;
    end
  end

  // Checks ignore motion; value is taken in displayed units
  assign pre_round = round_int(pre_val, DISP_INT);
  assign pre_oc = pre_req && OVER_CAP;
  assign pre_uz = pre_req && !OVER_CAP && UNDER_ZERO;
  assign pre_big = pre_req && !OVER_CAP && !UNDER_ZERO && (pre_round > CAPACITY);
  assign pre_ok = pre_req && !OVER_CAP && !UNDER_ZERO && !(pre_round > CAPACITY);

  // Pushbutton path yields to a preset arriving in the same cycle
  assign pb_small = (st_q == SZT_TR_IDLE) && pb_req && !pre_req && (gross_x <= 0);
  assign pb_exec = !pre_req && (((st_q == SZT_TR_IDLE) && pb_req && !pb_small && !MOTION)
    || ((st_q == SZT_TR_WAIT) && !MOTION));
  assign wait_to = (st_q == SZT_TR_WAIT) && MOTION && (wcnt_q == CW'(TARE_WAIT - 1));

  // Motion wait; further key presses during the wait are not queued
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= SZT_TR_IDLE;
      wcnt_q <= '0;
    end else begin
      case (st_q)
        SZT_TR_IDLE: begin
          wcnt_q <= '0;
          if (pb_req && !pre_req && !pb_small && MOTION) begin
            st_q <= SZT_TR_WAIT;
          end
        end
        SZT_TR_WAIT: begin
          wcnt_q <= wcnt_q + CW'(1);
          if (pb_exec || wait_to || pre_req) begin
            st_q <= SZT_TR_IDLE;
          end
        end
        default: st_q <= SZT_TR_IDLE;
      endcase
    end
  end

  // Tare register: stored as a number, so a leading zero is never lost
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tare_q <= '0;
      net_mode_q <= 1'b0;
    end else if (pre_ok) begin
      tare_q <= pre_round;
      net_mode_q <= 1'b1;
    end else if (pb_exec) begin
      tare_q <= gross_w;
      net_mode_q <= 1'b1;
    end
  end

  // Tare label; memory label under sign correction until a transaction ends
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      label_q <= SZT_LBL_NONE;
    end else if (pre_ok) begin
      label_q <= (tbl_req && NET_SIGN_CORR_EN) ? SZT_LBL_M : SZT_LBL_PRESET;
    end else if (pb_exec) begin
      label_q <= SZT_LBL_T;
    end else if (TXN_DONE && label_q == SZT_LBL_M) begin
      label_q <= SZT_LBL_PRESET;
    end
  end

  // Active table record
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_q <= '0;
      rec_act_q <= 1'b0;
    end else if (pre_ok && tbl_req) begin
      sel_q <= tbl_idx;
      rec_act_q <= 1'b1;
    end
  end

  a_pb_disabled: assert property (pin_rise[1] && !KEY_ENTRY_VALID && !PB_TARE_EN && !pre_req
    && (st_q == SZT_TR_IDLE) |=> (st_q == SZT_TR_IDLE) && $stable(tare_q))
    else $error("disabled pushbutton tare acted");
  a_pb_take: assert property (pb_exec |=> net_mode_q && (tare_q == $past(gross_w)))
    else $error("pushbutton tare did not store gross");
  sequence s_wait_moving;
    (st_q == SZT_TR_WAIT) && MOTION && !pre_req;
  endsequence
  a_wait_abort: assert property (s_wait_moving and wait_to |=> ERR_TARE_MOTION && $stable(tare_q)
    && (st_q == SZT_TR_IDLE))
    else $error("motion timeout did not abort tare");
  a_wait_exec: assert property ((st_q == SZT_TR_WAIT) && !MOTION && !pre_req
    |=> (tare_q == $past(gross_w)) && (st_q == SZT_TR_IDLE))
    else $error("settled weight not tared during wait");
  a_too_small: assert property (pb_small |=> ERR_TARE_SMALL && $stable(tare_q))
    else $error("non-positive gross tare not refused");
  a_kb_disabled: assert property (pin_rise[1] && KEY_ENTRY_VALID && !KB_TARE_EN && !SER_PRE_VALID
    && !PLC_PRE_VALID && !tbl_req && (st_q == SZT_TR_IDLE) |=> $stable(tare_q))
    else $error("disabled keyboard tare acted");
  a_pre_overcap: assert property (pre_oc |=> ERR_TARE_OVERCAP && $stable(tare_q))
    else $error("preset tare over capacity accepted");
  a_pre_below: assert property (pre_uz |=> ERR_TARE_BELOW_ZERO && $stable(tare_q))
    else $error("preset tare under zero accepted");
  a_pre_replace: assert property (pre_ok |=> (tare_q == $past(pre_round)) && (TARE_LABEL != 2'(SZT_LBL_T)))
    else $error("preset tare not replaced");

  // Error pulses, one cycle each
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ERR_ZERO_RANGE <= 1'b0;
      ERR_TARE_MOTION <= 1'b0;
      ERR_TARE_SMALL <= 1'b0;
      ERR_TARE_OVERCAP <= 1'b0;
      ERR_TARE_BELOW_ZERO <= 1'b0;
      ERR_TARE_RANGE <= 1'b0;
      ERR_TBL_MISS <= 1'b0;
    end else begin
      ERR_ZERO_RANGE <= (pu_st_q == SZT_PU_DONE) && zero_req && !MOTION && !in_semi_band;
      ERR_TARE_MOTION <= wait_to && !pre_req;
      ERR_TARE_SMALL <= pb_small;
      ERR_TARE_OVERCAP <= pre_oc;
      ERR_TARE_BELOW_ZERO <= pre_uz;
      ERR_TARE_RANGE <= pre_big;
      ERR_TBL_MISS <= tbl_miss;
    end
  end

  // Sign-corrected weight fields; also feed the stored totals
  logic signed [W:0] tare_x;
  logic swap;
  assign tare_x = net_mode_q ? $signed({tare_q[W-1], tare_q}) : '0;
  assign swap = NET_SIGN_CORR_EN && (gross_x < tare_x);
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DISP_GROSS <= '0;
      DISP_TARE <= '0;
      DISP_NET <= '0;
    end else begin
      DISP_GROSS <= swap ? tare_x[W-1:0] : gross_w;
      DISP_TARE <= swap ? gross_w : tare_x[W-1:0];
      DISP_NET <= swap ? W'(tare_x - gross_x) : W'(gross_x - tare_x);
    end
  end

  a_nsc_positive: assert property (NET_SIGN_CORR_EN |=> !DISP_NET[W-1])
    else $error("corrected net went negative");

  // Tare records
  szt_tare_table #(
    .W(W),
    .TW(W + 8),
    .N_REC(N_REC),
    .ID_CHARS(ID_CHARS),
    .DESC_CHARS(DESC_CHARS)
  ) u_table (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .wr_en(TBL_WR_EN),
    .wr_idx(TBL_WR_IDX),
    .wr_id(TBL_WR_ID),
    .wr_desc(TBL_WR_DESC),
    .wr_tare(TBL_WR_TARE),
    .pre_wr_en(pre_ok && !tbl_req && rec_act_q),
    .tot_en(TXN_DONE && TOTAL_EN && rec_act_q),
    .act_idx(sel_q),
    .pre_wr_val(pre_round),
    .tot_val(TOTAL_SEL_NET ? DISP_NET : DISP_GROSS),
    .look_id(TBL_RECALL_ID),
    .look_hit(look_hit),
    .look_idx(look_idx),
    .rec_idx(tbl_idx),
    .rec_tare(rec_tare),
    .sel_desc(TBL_DESC),
    .sel_total(TBL_TOTAL),
    .sel_count(TBL_COUNT)
  );

  // Status outputs straight from state
  assign ZERO_REF = zero_ref_q;
  assign NET_MODE = net_mode_q;
  assign TARE_LABEL = label_q;
  assign PU_ZERO_DONE = (pu_st_q == SZT_PU_DONE);
  assign TARE_WAITING = (st_q == SZT_TR_WAIT);
  assign TBL_SEL_IDX = sel_q;

endmodule // szt_zero_tare

// ---- szt_fe_model.sv ----
`timescale 1ns/1ps
module szt_fe_model
  import szt_pkg::*;
#(
  parameter int W = 24,
  parameter int CAP = 1000
) (
  // Load placed on the platform
  input wire logic [W-1:0] load,
  input wire logic shaking,
  // Front-end outputs
  output logic [W-1:0] raw_wt,
  output logic motion,
  output logic over_cap,
  output logic under_zero,
  output logic [W-1:0] capacity
);
  // Limit flags follow the load, motion follows shaking; no filtering, so tests set conditions directly
  assign raw_wt = load;
  assign motion = shaking;
  assign capacity = W'(CAP);
  assign over_cap = $signed(load) > $signed(W'(CAP));
  assign under_zero = $signed(load) < 0;
endmodule // szt_fe_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import szt_pkg::*;
;
  logic clk, arst_n, pu_en, pb_en, kb_en, nsc_en, tot_en, key_t, entry_v, rx_v, plc_z, ser_v, wr_en, id_v, txn;
  logic zk, zd, app_z, plc_v, idx_v, sel_net;
  logic shaking, mot, ovc, unz, net_mode, pu_done, waiting;
  logic [23:0] load, raw, cap, dint, entry, ser_val, wr_tare, gross, tare, net, zref;
  logic [7:0] rx_ch;
  logic [31:0] wr_id, rc_id, total;
  logic [319:0] desc_o;
  logic [1:0] label;
  logic [3:0] wr_idx, sel_idx;
  logic [15:0] cnt;
  logic [6:0] ev;
  int ne [7];
  int err_count, checks_done;

  szt_fe_model szt_fe_model_i (.load(load), .shaking(shaking), .raw_wt(raw), .motion(mot), .over_cap(ovc),
    .under_zero(unz), .capacity(cap));

  szt_zero_tare #(.TARE_WAIT(20)) szt_zero_tare_i (.CORE_CLK(clk), .ARST_N(arst_n), .RAW_WT(raw), .MOTION(mot),
    .OVER_CAP(ovc), .UNDER_ZERO(unz), .CAPACITY(cap), .DISP_INT(dint), .PWRUP_ZERO_EN(pu_en),
    .PWRUP_PCT_ABOVE(7'h05), .PWRUP_PCT_BELOW(7'h05), .SEMI_ZERO_PCT(7'h05), .PB_TARE_EN(pb_en),
    .KB_TARE_EN(kb_en), .NET_SIGN_CORR_EN(nsc_en), .TOTAL_EN(tot_en), .TOTAL_SEL_NET(sel_net), .ZERO_KEY(zk),
    .TARE_KEY(key_t), .ZERO_DIN(zd), .SER_RX_VALID(rx_v), .SER_RX_CHAR(rx_ch), .PLC_ZERO(plc_z),
    .APP_ZERO(app_z), .KEY_ENTRY_VALID(entry_v), .KEY_ENTRY_VAL(entry), .SER_PRE_VALID(ser_v),
    .SER_PRE_VAL(ser_val), .PLC_PRE_VALID(plc_v), .PLC_PRE_VAL(ser_val), .TBL_WR_EN(wr_en), .TBL_WR_IDX(wr_idx),
    .TBL_WR_ID(wr_id), .TBL_WR_DESC({288'h0, wr_id}), .TBL_WR_TARE(wr_tare), .TBL_RECALL_IDX_VALID(idx_v),
    .TBL_RECALL_IDX(wr_idx), .TBL_RECALL_ID_VALID(id_v), .TBL_RECALL_ID(rc_id), .TXN_DONE(txn),
    .DISP_GROSS(gross), .DISP_TARE(tare), .DISP_NET(net), .ZERO_REF(zref), .NET_MODE(net_mode),
    .TARE_LABEL(label), .PU_ZERO_DONE(pu_done), .TARE_WAITING(waiting), .TBL_SEL_IDX(sel_idx), .TBL_DESC(desc_o),
    .TBL_TOTAL(total), .TBL_COUNT(cnt), .ERR_ZERO_RANGE(ev[0]), .ERR_TARE_MOTION(ev[1]), .ERR_TARE_SMALL(ev[2]),
    .ERR_TARE_OVERCAP(ev[3]), .ERR_TARE_BELOW_ZERO(ev[4]), .ERR_TARE_RANGE(ev[5]), .ERR_TBL_MISS(ev[6]));

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Error pulses last one cycle; tally mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    for (int i = 0; i < 7; i++) begin
      if (ev[i] === 1'b1) ne[i]++;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Held long enough to clear the pin synchroniser
  task automatic press();
    key_t = 1'b1;
    cyc(6);
    key_t = 1'b0;
    cyc(6);
  endtask

  task automatic preset(input logic [23:0] v);
    ser_val = v;
    ser_v = 1'b1;
    cyc(1);
    ser_v = 1'b0;
    cyc(2);
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    {arst_n, pb_en, kb_en, nsc_en, tot_en, key_t, entry_v, rx_v, plc_z, ser_v, wr_en, id_v, txn} = '0;
    {pu_en, shaking, load, dint, entry, ser_val, wr_tare, rx_ch, wr_id, rc_id, wr_idx} = '0;
    {zk, zd, app_z, plc_v, idx_v} = '0;
    sel_net = 1'b1;
    pu_en = 1'b1;
    shaking = 1'b1;
    load = 24'h00000a;
    dint = 24'h00000a;
    cyc(16);
    arst_n = 1'b1;
    cyc(5);
    chk(pu_done, 0);
    shaking = 1'b0;
    cyc(2);
    chk(zref, 10);
    chk(pu_done, 1);
    load = 24'h00001e;
    plc_z = 1'b1;
    cyc(1);
    plc_z = 1'b0;
    chk(zref, 30);
    load = 24'h000028;
    app_z = 1'b1;
    cyc(1);
    app_z = 1'b0;
    chk(zref, 40);
    load = 24'h000014;
    zk = 1'b1;
    cyc(6);
    zk = 1'b0;
    cyc(6);
    chk(zref, 20);
    load = 24'h00001e;
    zd = 1'b1;
    cyc(6);
    zd = 1'b0;
    cyc(6);
    chk(zref, 30);
    load = 24'h000064;
    rx_ch = 8'h5a;
    rx_v = 1'b1;
    cyc(1);
    rx_v = 1'b0;
    cyc(1);
    chk(ne[0], 1);
    chk(zref, 30);
    load = 24'h000082;
    press();
    chk(net_mode, 0);
    pb_en = 1'b1;
    load = 24'h000014;
    press();
    chk(ne[2], 1);
    chk(net_mode, 0);
    load = 24'h000082;
    shaking = 1'b1;
    press();
    chk(waiting, 1);
    shaking = 1'b0;
    cyc(3);
    chk(tare, 100);
    chk({net_mode, label}, 3'h5);
    chk(net, 0);
    shaking = 1'b1;
    press();
    cyc(30);
    chk(ne[1], 1);
    chk(tare, 100);
    entry_v = 1'b1;
    entry = 24'h00012c;
    press();
    chk(tare, 100);
    entry_v = 1'b0;
    preset(24'h00002d);
    chk(tare, 50);
    chk(label, 2);
    ser_val = 24'h000046;
    plc_v = 1'b1;
    cyc(1);
    plc_v = 1'b0;
    cyc(2);
    chk(tare, 70);
    preset(24'h00002c);
    chk(tare, 40);
    shaking = 1'b0;
    preset(24'h0007d0);
    chk(ne[5], 1);
    load = 24'h0007d0;
    preset(24'h000014);
    chk(ne[3], 1);
    load = 24'hfffffb;
    preset(24'h000014);
    chk(ne[4], 1);
    chk(tare, 40);
    dint = 24'h000001;
    load = 24'h00002e;
    preset(24'h000035);
    chk(net, 24'hffffdb);
    nsc_en = 1'b1;
    cyc(2);
    chk(gross, 24'h000035);
    chk(tare, 24'h000010);
    chk(net, 24'h000025);
    wr_idx = 4'h2;
    wr_id = 32'h32316261;
    wr_tare = 24'h000014;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
    rc_id = 32'h32314241;
    id_v = 1'b1;
    cyc(1);
    id_v = 1'b0;
    cyc(2);
    chk(sel_idx, 2);
    chk(label, 3);
    tot_en = 1'b1;
    txn = 1'b1;
    cyc(1);
    txn = 1'b0;
    cyc(2);
    chk(cnt, 1);
    chk(label, 2);
    chk(total, 4);
    chk(desc_o[31:0], 32'h32316261);
    wr_idx = 4'h5;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
    idx_v = 1'b1;
    cyc(1);
    idx_v = 1'b0;
    rc_id = 32'h00000000;
    id_v = 1'b1;
    cyc(1);
    id_v = 1'b0;
    cyc(2);
    chk(sel_idx, 5);
    chk(ne[6], 1);
    sel_net = 1'b0;
    txn = 1'b1;
    cyc(1);
    txn = 1'b0;
    cyc(2);
    chk(total, 20);
    chk(cnt, 1);
    end_sim();
  end
endmodule // tb_top
